/* File: fsve_pkg.sv */
// Constants, opcodes and operand classes for the special-value exception unit.
// Assumes an 80-bit extended register format: sign, 15-bit exponent, 64-bit significand.
package fsve_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IMASK  = 4'h8;
    localparam logic [3:0] ADDR_TAG    = 4'hC;

    // ----------------------------------------
    // Control word fields
    // ----------------------------------------
    localparam int         CTL_IM      = 0;
    localparam int         CTL_DM      = 1;
    localparam int         CTL_OM      = 3;
    localparam int         CTL_UM      = 4;
    localparam int         CTL_PC_LO   = 8;
    localparam int         CTL_RC_LO   = 10;
    localparam int         CTL_IC      = 12;
    localparam logic [15:0] CTRL_RESET = 16'h037F;

    // ----------------------------------------
    // Status word fields
    // ----------------------------------------
    localparam int         ST_IE       = 0;
    localparam int         ST_DE       = 1;
    localparam int         ST_OE       = 3;
    localparam int         ST_UE       = 4;
    localparam int         ST_PE       = 5;
    localparam int         ST_SF       = 6;
    localparam int         ST_C1       = 9;
    localparam int         ST_STICKY_W = 7;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [6:0] IMASK_RESET = 7'h00;

    // ----------------------------------------
    // Encodings
    // ----------------------------------------
    localparam logic [1:0]  TAG_VALID   = 2'h0;
    localparam logic [1:0]  TAG_ZERO    = 2'h1;
    localparam logic [1:0]  TAG_SPECIAL = 2'h2;
    localparam logic [1:0]  TAG_EMPTY   = 2'h3;
    localparam logic [1:0]  PC_SINGLE   = 2'h0;
    localparam logic [1:0]  PC_DOUBLE   = 2'h2;
    localparam logic [1:0]  RC_DOWN     = 2'h1;
    localparam logic [1:0]  RC_UP       = 2'h2;
    localparam logic [1:0]  RC_CHOP     = 2'h3;
    localparam logic [14:0] EXP_MAX     = 15'h7FFF;
    localparam logic [14:0] EXP_ADJ     = 15'h6000;
    localparam logic [79:0] QNAN_INDEF  = 80'hFFFF_C000_0000_0000_0000;

    typedef enum logic [3:0] {
        OP_NONE, OP_WRITE_REG, OP_LOAD_ENV, OP_STORE_ENV, OP_ARITH,
        OP_TRANSC, OP_EXTRACT, OP_COMPARE, OP_STORE_INT, OP_STORE_BCD
    } fsve_op_type;

    typedef enum logic [2:0] {
        CL_VALID, CL_ZERO, CL_DENORM, CL_INF, CL_QNAN, CL_SNAN, CL_UNSUP
    } fsve_class_type;

endpackage

/* File: fsve_unit.sv */
// Special-operand classification, tag handling and exception response of the FPU.
// Assumes the integer core issues one op per cycle at most and an arithmetic datapath
// supplies a rounded extended result with overflow, tiny and inexact indications.
//
// Functional notes
// - Infinity-control bit stored and readable; arithmetic always uses affine infinities.
// - Loaded tags only mark occupied (00,01,10) or empty (11).
// - Operand class always comes from register contents, not loaded tag.
// - Store and save ops recompute tags of occupied registers before output.
// - Unsupported formats, pseudo-zero and unnormal included, get special tag 10.
// - Signaling and quiet NaNs are distinguished; produced NaNs are always quiet.
// - Signaling NaN raises invalid; quiet NaN only for compare, integer, decimal stores.
// - Pseudo and unnormal operands raise invalid; such values are never produced.
// - With denormal masked, denormal operands are normalized before use.
// - Denormal exception also raised for transcendental and extract instructions.
// - Masked overflow under round-toward-zero gives largest finite of correct sign.
// - Unmasked overflow also sets the precision flag.
// - Unmasked overflow to stack rounds significand per precision control or opcode.
// - Masked underflow signalled only when tiny and denormalizing loses accuracy.
// - Unmasked underflow to stack adjusts exponent, then rounds per precision.
// - Unmasked stack fault sets invalid and stack fault; condition one marks overflow.
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module fsve_unit #(
    parameter int NREG = 8
) (
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   op_valid_i,
    input  wire fsve_pkg::fsve_op_type  op_code_i,
    input  wire logic [2:0]             op_reg_i,
    input  wire logic [79:0]            op_data_i,
    input  wire logic [15:0]            tag_word_i,
    input  wire logic                   to_stack_i,
    input  wire logic                   pc_governed_i,
    input  wire logic [1:0]             op_pc_i,
    input  wire logic [79:0]            res_i,
    input  wire logic                   res_ovf_i,
    input  wire logic                   res_tiny_i,
    input  wire logic                   res_inexact_i,
    input  wire logic                   stk_ovf_i,
    input  wire logic                   stk_unf_i,
    input  wire logic [3:0]             bus_addr_i,
    input  wire logic [15:0]            bus_wdata_i,
    input  wire logic                   bus_wr_i,
    input  wire logic                   bus_rd_i,
    output logic [15:0]                 bus_rdata_o,
    output logic                        done_o,
    output logic [79:0]                 result_o,
    output logic                        result_wr_o,
    output logic [63:0]                 norm_sig_o,
    output logic [5:0]                  norm_shift_o,
    output logic [15:0]                 tag_word_o,
    output logic                        irq_o
);
    import fsve_pkg::*;

    // Elaboration-time refusal: the tag word and index width are fixed at eight registers
    if (NREG != 8) begin
        $error("fsve_unit supports exactly eight stack registers");
    end

    // ----------------------------------------
    // Classification
    // ----------------------------------------
    function automatic fsve_class_type classify(input logic [79:0] v);
        fsve_class_type c;
        c = CL_VALID;
        if (v[78:64] == EXP_MAX) begin
            if (!v[63])                c = CL_UNSUP;
            else if (v[62:0] == 63'h0) c = CL_INF;
            else if (v[62])            c = CL_QNAN;
            else                       c = CL_SNAN;
        end else if (v[78:64] == 15'h0) begin
            if (v[63:0] == 64'h0)      c = CL_ZERO;
            else                       c = CL_DENORM;
        end else if (!v[63]) begin
            c = CL_UNSUP;
        end
        return c;
    endfunction

    function automatic logic [1:0] tag_of(input fsve_class_type c);
        logic [1:0] t;
        unique case (c)
            CL_VALID: t = TAG_VALID;
            CL_ZERO:  t = TAG_ZERO;
            default:  t = TAG_SPECIAL;
        endcase
        return t;
    endfunction

    // Round to nearest at the precision boundary; a carry out bumps the exponent
    function automatic logic [79:0] round_pc(input logic [79:0] v, input logic [1:0] pc);
        logic [64:0] sum;
        logic [63:0] keep;
        logic [63:0] half;
        keep = 64'hFFFF_FFFF_FFFF_FFFF;
        half = 64'h0;
        if (pc == PC_SINGLE) begin
            keep = 64'hFFFF_FF00_0000_0000;
            half = 64'h0000_0080_0000_0000;
        end else if (pc == PC_DOUBLE) begin
            keep = 64'hFFFF_FFFF_FFFF_F800;
            half = 64'h0000_0000_0000_0400;
        end
        sum = {1'b0, v[63:0]} + {1'b0, half};
        if (sum[64]) return {v[79], v[78:64] + 15'h1, 64'h8000_0000_0000_0000};
        return {v[79:64], sum[63:0] & keep};
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [79:0]    stack_reg [NREG];
    logic [NREG-1:0] occupied_reg;
    logic [15:0]    ctrl_reg;
    logic [15:0]    status_reg;
    logic [6:0]     imask_reg;
    logic [15:0]    status_next;

    fsve_class_type opnd_class;
    logic [79:0]    opnd;
    logic           is_arith;
    logic           q_faults;
    logic           ev_inv;
    logic           ev_den;
    logic           ev_ovf;
    logic           ev_unf;
    logic           ev_pe;
    logic           stk_fault;
    logic           blocked;
    logic           wr_stack;
    logic [79:0]    res_next;
    logic [15:0]    tags_now;
    logic [5:0]     lz;
    logic [1:0]     pc_eff;

    assign opnd = stack_reg[op_reg_i];

    always_comb begin
        opnd_class = classify(opnd);
        is_arith   = op_code_i inside {OP_ARITH, OP_TRANSC, OP_EXTRACT};
        q_faults   = op_code_i inside {OP_COMPARE, OP_STORE_INT, OP_STORE_BCD};
        stk_fault  = op_valid_i && (stk_ovf_i || stk_unf_i);
        ev_inv     = op_valid_i && (is_arith || q_faults)
                   && (opnd_class == CL_SNAN
                   || opnd_class == CL_UNSUP
                   || (opnd_class == CL_QNAN && q_faults));
        ev_den     = op_valid_i && is_arith && opnd_class == CL_DENORM;
        ev_ovf     = op_valid_i && is_arith && !ev_inv && res_ovf_i;
        ev_unf     = op_valid_i && is_arith && !ev_inv && res_tiny_i
                   && (!ctrl_reg[CTL_UM] || res_inexact_i);
        ev_pe      = op_valid_i && is_arith && !ev_inv
                   && (res_inexact_i || res_ovf_i);
        blocked    = (ev_inv && !ctrl_reg[CTL_IM]) || (ev_den && !ctrl_reg[CTL_DM])
                   || (stk_fault && !ctrl_reg[CTL_IM]);
        wr_stack   = op_valid_i && is_arith && to_stack_i && !blocked;
        pc_eff     = pc_governed_i ? ctrl_reg[CTL_PC_LO +: 2] : op_pc_i;
    end

    // ----------------------------------------
    // Result selection
    // ----------------------------------------
    always_comb begin
        res_next = res_i;
        if (ev_inv || stk_fault) begin
            res_next = QNAN_INDEF;
        end else if (ev_ovf && ctrl_reg[CTL_OM]) begin
            // Affine closure only; the infinity-control bit is never consulted
            if (ctrl_reg[CTL_RC_LO +: 2] == RC_CHOP
                || (ctrl_reg[CTL_RC_LO +: 2] == RC_DOWN && !res_i[79])
                || (ctrl_reg[CTL_RC_LO +: 2] == RC_UP && res_i[79]))
                res_next = {res_i[79], EXP_MAX - 15'h1, 64'hFFFF_FFFF_FFFF_FFFF};
            else
                res_next = {res_i[79], EXP_MAX, 64'h8000_0000_0000_0000};
        end else if (ev_ovf) begin
            res_next = round_pc({res_i[79], res_i[78:64] - EXP_ADJ, res_i[63:0]},
                                pc_eff);
        end else if (ev_unf && !ctrl_reg[CTL_UM]) begin
            // Extended precision where precision control does not govern the op
            res_next = round_pc({res_i[79], res_i[78:64] + EXP_ADJ, res_i[63:0]},
                                pc_governed_i ? ctrl_reg[CTL_PC_LO +: 2] : 2'h3);
        end else if (classify(res_i) == CL_QNAN || classify(res_i) == CL_SNAN) begin
            res_next = {res_i[79:63], 1'b1, res_i[61:0]};
        end
    end

    // Leading-zero count for normalizing a denormal significand
    always_comb begin
        lz = 6'h0;
        for (int i = 0; i < 64; i++) begin
            if (opnd[i]) lz = 6'(63 - i);
        end
    end

    always_comb begin
        for (int r = 0; r < NREG; r++) begin
            tags_now[2*r +: 2] = occupied_reg[r] ? tag_of(classify(stack_reg[r]))
                                                 : TAG_EMPTY;
        end
    end

    // ----------------------------------------
    // Register stack and occupancy
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (op_valid_i && op_code_i == OP_WRITE_REG) begin
            stack_reg[op_reg_i] <= op_data_i;
        end else if (wr_stack) begin
            stack_reg[op_reg_i] <= res_next;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            occupied_reg <= '0;
        end else if (op_valid_i && op_code_i == OP_LOAD_ENV) begin
            for (int r = 0; r < NREG; r++) begin
                occupied_reg[r] <= tag_word_i[2*r +: 2] != TAG_EMPTY;
            end
        end else if ((op_valid_i && op_code_i == OP_WRITE_REG) || wr_stack) begin
            occupied_reg[op_reg_i] <= 1'b1;
        end
    end

    // ----------------------------------------
    // Core-facing outputs
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            done_o       <= 1'b0;
            result_o     <= '0;
            result_wr_o  <= 1'b0;
            norm_sig_o   <= '0;
            norm_shift_o <= '0;
        end else begin
            done_o      <= op_valid_i;
            result_wr_o <= wr_stack;
            if (op_valid_i && is_arith) begin
                result_o <= res_next;
                if (opnd_class == CL_DENORM && ctrl_reg[CTL_DM]) begin
                    norm_sig_o   <= opnd[63:0] << lz;
                    norm_shift_o <= lz;
                end else begin
                    norm_sig_o   <= opnd[63:0];
                    norm_shift_o <= '0;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            tag_word_o <= {NREG{TAG_EMPTY}};
        end else if (op_valid_i && op_code_i == OP_STORE_ENV) begin
            tag_word_o <= tags_now;
        end
    end

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ctrl_reg  <= CTRL_RESET;
            imask_reg <= IMASK_RESET;
        end else if (bus_wr_i) begin
            if (bus_addr_i == ADDR_CTRL)  ctrl_reg  <= bus_wdata_i;
            if (bus_addr_i == ADDR_IMASK) imask_reg <= bus_wdata_i[6:0];
        end
    end

    // Sticky flags: a read clears them, but an event in the same cycle wins
    always_comb begin
        status_next = status_reg;
        if (bus_rd_i && bus_addr_i == ADDR_STATUS) status_next[6:0] = '0;
        if (ev_inv || stk_fault) status_next[ST_IE] = 1'b1;
        if (ev_den) status_next[ST_DE] = 1'b1;
        if (ev_ovf) status_next[ST_OE] = 1'b1;
        if (ev_unf) status_next[ST_UE] = 1'b1;
        if (ev_pe || (ev_ovf && !ctrl_reg[CTL_OM])) status_next[ST_PE] = 1'b1;
        if (stk_fault) begin
            status_next[ST_SF] = 1'b1;
            status_next[ST_C1] = stk_ovf_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            status_reg <= STATUS_RESET;
            irq_o      <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq_o      <= |(status_next[6:0] & imask_reg);
        end
    end

    // Unmapped addresses read as zero
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            bus_rdata_o <= '0;
        end else if (bus_rd_i) begin
            unique case (bus_addr_i)
                ADDR_CTRL:   bus_rdata_o <= ctrl_reg;
                ADDR_STATUS: bus_rdata_o <= status_reg;
                ADDR_IMASK:  bus_rdata_o <= {9'h0, imask_reg};
                ADDR_TAG:    bus_rdata_o <= tag_word_o;
                default:     bus_rdata_o <= '0;
            endcase
        end else begin
            bus_rdata_o <= '0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_quiet_nan_out: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        done_o && result_o[78:64] == EXP_MAX && result_o[62:0] != 63'h0 |-> result_o[62])
        else $error("produced NaN is not quiet");

    a_ovf_sets_pe: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ev_ovf && !ctrl_reg[CTL_OM] |=> status_reg[ST_PE] && status_reg[ST_OE])
        else $error("unmasked overflow without precision flag");

    a_chop_max_finite: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ev_ovf && ctrl_reg[CTL_OM] && ctrl_reg[CTL_RC_LO +: 2] == RC_CHOP
        |=> result_o[78:0] == {EXP_MAX - 15'h1, 64'hFFFF_FFFF_FFFF_FFFF})
        else $error("chop overflow not largest finite");

    a_snan_invalid: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        op_valid_i && is_arith && opnd_class == CL_SNAN |=> status_reg[ST_IE])
        else $error("signaling NaN did not raise invalid");

    a_blocked_keeps: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        op_valid_i && is_arith && blocked |=> !result_wr_o && $stable(occupied_reg))
        else $error("faulted op changed destination");

    a_stack_fault: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        op_valid_i && stk_ovf_i |=> status_reg[ST_IE] && status_reg[ST_SF] && status_reg[ST_C1])
        else $error("stack overflow flags wrong");

    a_env_load_tag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        op_valid_i && op_code_i == OP_LOAD_ENV
        |=> occupied_reg[0] == ($past(tag_word_i[1:0]) != TAG_EMPTY))
        else $error("loaded tag misclassified");

    a_irq_level: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        irq_o == |(status_reg[6:0] & $past(imask_reg)))
        else $error("interrupt does not follow status");

endmodule

/* File: fsve_core_model.sv */
// Model of the integer core that issues floating-point ops to the unit.
// Assumes one op at a time, launched just after a rising edge of the shared clock.
`timescale 1ns/1ps
module fsve_core_model (
    input  wire logic               core_clk_i,
    output logic                    op_valid_o,
    output fsve_pkg::fsve_op_type   op_code_o,
    output logic [2:0]              op_reg_o,
    output logic [79:0]             op_data_o,
    output logic [15:0]             tag_word_o,
    output logic [79:0]             res_o,
    output logic [6:0]              flags_o
);
    import fsve_pkg::*;

    initial begin
        op_valid_o = 1'b0;
        op_code_o  = OP_NONE;
        op_reg_o   = 3'h0;
        op_data_o  = 80'h0;
        tag_word_o = 16'hFFFF;
        res_o      = 80'h0;
        flags_o    = 7'h00;
    end

    // ----------------------------------------
    // One op; flags are {su, so, inexact, tiny, ovf, to_stack, pc_governed}
    // ----------------------------------------
    task automatic issue(input fsve_op_type c, input logic [2:0] r,
                         input logic [79:0] d, input logic [6:0] f);
        @(posedge core_clk_i);
        op_valid_o <= 1'b1;
        op_code_o  <= c;
        op_reg_o   <= r;
        op_data_o  <= d;
        res_o      <= d;
        tag_word_o <= d[15:0];
        flags_o    <= f;
        @(posedge core_clk_i);
        op_valid_o <= 1'b0;
        op_code_o  <= OP_NONE;
        // Released fields are scrambled so a late sample cannot pass by luck
        op_data_o  <= ~d;
        res_o      <= ~d;
        tag_word_o <= ~d[15:0];
        flags_o    <= 7'h00;
    endtask
endmodule

/* File: fpu_special_value_exceptions_tb_top.sv */
// Self-checking bench for the special-value exception unit.
// Assumes the core model in fsve_core_model.sv and a 20 MHz clock.
`timescale 1ns/1ps
module fpu_special_value_exceptions_tb_top;
    import fsve_pkg::*;
    localparam logic [79:0] V_SNAN = {1'b0, 15'h7FFF, 64'hA000_0000_0000_0000};
    localparam logic [79:0] V_QNAN = {1'b0, 15'h7FFF, 64'hC000_0000_0000_0001};
    localparam logic [79:0] V_VAL  = {1'b0, 15'h3FFF, 64'h8000_0000_0000_0000};
    localparam logic [79:0] V_UNN  = {1'b0, 15'h3FFF, 64'h4000_0000_0000_0000};
    localparam logic [79:0] V_DEN  = {1'b0, 15'h0000, 64'h0000_0001_0000_0000};
    localparam logic [79:0] V_PINF = {1'b0, 15'h7FFF, 64'h0000_0000_0000_0000};
    localparam logic [79:0] V_SIG  = {1'b0, 15'h0000, 64'hABCD_EF80_0000_0001};
    logic               core_clk, rst_n, op_valid, bus_wr, bus_rd, done, result_wr, irq;
    fsve_op_type        op_code;
    logic [2:0]         op_reg;
    logic [79:0]        op_data, res, result;
    logic [15:0]        tag_in, tag_out, bus_wdata, bus_rdata, s;
    logic [6:0]         flags;
    logic [3:0]         bus_addr;
    logic [1:0]         op_pc;
    logic [63:0]        norm_sig;
    logic [5:0]         norm_shift;
    int                 mismatches, num_checks, cycles;

    fsve_core_model core (.core_clk_i(core_clk), .op_valid_o(op_valid), .op_code_o(op_code),
        .op_reg_o(op_reg), .op_data_o(op_data), .tag_word_o(tag_in), .res_o(res),
        .flags_o(flags));
    fsve_unit #(.NREG(8)) dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .op_valid_i(op_valid),
        .op_code_i(op_code), .op_reg_i(op_reg), .op_data_i(op_data), .tag_word_i(tag_in),
        .to_stack_i(flags[1]), .pc_governed_i(flags[0]), .op_pc_i(op_pc), .res_i(res),
        .res_ovf_i(flags[2]), .res_tiny_i(flags[3]), .res_inexact_i(flags[4]),
        .stk_ovf_i(flags[5]), .stk_unf_i(flags[6]), .bus_addr_i(bus_addr),
        .bus_wdata_i(bus_wdata), .bus_wr_i(bus_wr), .bus_rd_i(bus_rd), .bus_rdata_o(bus_rdata),
        .done_o(done), .result_o(result), .result_wr_o(result_wr), .norm_sig_o(norm_sig),
        .norm_shift_o(norm_shift), .tag_word_o(tag_out), .irq_o(irq));

    // ----------------------------------------
    // Clock, hang guard, shared tasks
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge core_clk);
        bus_wr    <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge core_clk);
        bus_rd   <= 1'b0;
        #1;
        s = bus_rdata;
    endtask
    task automatic op(input fsve_op_type c, input logic [2:0] r, input logic [79:0] d,
                      input logic [6:0] f);
        core.issue(c, r, d, f);
        #1;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_ctrl();
        wr(ADDR_CTRL, 16'h137F);
        wr(4'h2, 16'hFFFF);
        rd(4'h2);
        rd(ADDR_CTRL);
        chk(s, 16'h137F);
        // Infinity control set, nearest rounding: masked overflow still closes to affine infinity
        op(OP_WRITE_REG, 3'h7, V_VAL, 7'h00);
        op(OP_ARITH, 3'h7, {1'b1, 15'h0001, 64'h8000_0000_0000_0000}, 7'h05);
        chk(result, {1'b1, EXP_MAX, 64'h8000_0000_0000_0000});
        wr(ADDR_CTRL, CTRL_RESET);
    endtask
    task automatic t_tags();
        logic [79:0] vals[6];
        vals = '{V_VAL, 80'h0, V_UNN, V_SNAN, V_QNAN, V_DEN};
        for (int i = 0; i < 6; i++) op(OP_WRITE_REG, i[2:0], vals[i], 7'h00);
        op(OP_LOAD_ENV, 3'h0, 80'hFAAA, 7'h00);
        op(OP_STORE_ENV, 3'h0, 80'h0, 7'h00);
        chk(tag_out, 16'hFAA4);
        // Invalid unmasked: the faulting write must not land
        wr(ADDR_CTRL, 16'h037E);
        op(OP_ARITH, 3'h3, V_VAL, 7'h03);
        chk(result_wr, 1'b0);
        chk(done, 1'b1);
        wr(ADDR_CTRL, CTRL_RESET);
        op(OP_STORE_ENV, 3'h0, 80'h0, 7'h00);
        chk(tag_out, 16'hFAA4);
        op(OP_LOAD_ENV, 3'h0, 80'hFAAB, 7'h00);
        op(OP_STORE_ENV, 3'h0, 80'h0, 7'h00);
        chk(tag_out, 16'hFAA7);
    endtask
    task automatic t_nan();
        fsve_op_type ops[4];
        ops = '{OP_ARITH, OP_COMPARE, OP_STORE_INT, OP_STORE_BCD};
        rd(ADDR_STATUS);
        for (int i = 0; i < 4; i++) begin
            op(ops[i], 3'h4, 80'h0, 7'h00);
            rd(ADDR_STATUS);
            chk(s[ST_IE], i != 0);
            op(ops[i], 3'h3, 80'h0, 7'h00);
            rd(ADDR_STATUS);
            chk(s[ST_IE], 1'b1);
        end
        op(OP_ARITH, 3'h3, 80'h0, 7'h00);
        chk({result[78:64], result[62]}, {EXP_MAX, 1'b1});
        op(OP_ARITH, 3'h1, V_SNAN, 7'h00);
        chk(result, {1'b0, EXP_MAX, 64'hE000_0000_0000_0000});
        op(OP_WRITE_REG, 3'h6, V_PINF, 7'h00);
        for (int i = 2; i < 7; i += 4) begin
            rd(ADDR_STATUS);
            op(OP_ARITH, i[2:0], 80'h0, 7'h00);
            rd(ADDR_STATUS);
            chk(s[ST_IE], 1'b1);
        end
    endtask
    task automatic t_denorm();
        fsve_op_type ops[3];
        ops = '{OP_ARITH, OP_TRANSC, OP_EXTRACT};
        for (int i = 0; i < 3; i++) begin
            rd(ADDR_STATUS);
            op(ops[i], 3'h5, 80'h0, 7'h00);
            chk({norm_sig, norm_shift}, {64'h8000_0000_0000_0000, 6'h1F});
            rd(ADDR_STATUS);
            chk(s[ST_DE], 1'b1);
        end
    endtask
    task automatic t_ovf_unf();
        wr(ADDR_CTRL, 16'h0F7F);
        op(OP_ARITH, 3'h7, {1'b1, 15'h7FFF, 64'h8000_0000_0000_0000}, 7'h07);
        chk(result_wr, 1'b1);
        chk(result, {1'b1, 15'h7FFE, 64'hFFFF_FFFF_FFFF_FFFF});
        wr(ADDR_CTRL, 16'h0077);
        rd(ADDR_STATUS);
        op(OP_ARITH, 3'h7, V_SIG | {1'b0, 15'h7000, 64'h0}, 7'h07);
        chk(result, {1'b0, 15'h1000, 64'hABCD_F000_0000_0000});
        rd(ADDR_STATUS);
        chk({s[ST_PE], s[ST_OE]}, 2'h3);
        op_pc <= PC_DOUBLE;
        op(OP_ARITH, 3'h7, V_SIG | {1'b0, 15'h7000, 64'h0}, 7'h06);
        chk(result, {1'b0, 15'h1000, 64'hABCD_EF80_0000_0000});
        wr(ADDR_CTRL, CTRL_RESET);
        for (int i = 0; i < 2; i++) begin
            op(OP_ARITH, 3'h7, V_VAL, i[0] ? 7'h1B : 7'h0B);
            rd(ADDR_STATUS);
            chk(s[ST_UE], i != 0);
        end
        wr(ADDR_CTRL, 16'h006F);
        op(OP_ARITH, 3'h7, V_SIG | {1'b0, 15'h0100, 64'h0}, 7'h0A);
        chk(result, V_SIG | {1'b0, 15'h6100, 64'h0});
    endtask
    task automatic t_stack();
        wr(ADDR_CTRL, 16'h037E);
        wr(ADDR_IMASK, 16'h0001);
        rd(ADDR_STATUS);
        op(OP_ARITH, 3'h7, V_VAL, 7'h20);
        @(posedge core_clk);
        #1;
        chk(irq, 1'b1);
        rd(ADDR_STATUS);
        chk(s & 16'h0241, 16'h0241);
        @(posedge core_clk);
        #1;
        chk(irq, 1'b0);
        op(OP_ARITH, 3'h7, V_VAL, 7'h40);
        rd(ADDR_STATUS);
        chk(s & 16'h0241, 16'h0041);
        // Masked in the interrupt mask: the event must stay silent
        wr(ADDR_IMASK, 16'h0000);
        op(OP_ARITH, 3'h7, V_VAL, 7'h20);
        @(posedge core_clk);
        #1;
        chk(irq, 1'b0);
    endtask

    initial begin
        rst_n = 1'b0;
        bus_addr = 4'h0;
        bus_wdata = 16'h0000;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        op_pc = 2'h3;
        mismatches = 0;
        num_checks = 0;
        cycles = 0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        chk(tag_out, 16'hFFFF);
        t_ctrl();
        t_tags();
        t_nan();
        t_denorm();
        t_ovf_unf();
        t_stack();
        close_out();
    end
endmodule
